// ### src/iosr_defines.vh
/*
 Constants for the I/O signal routing and conditioning block.
 Assumes plain Verilog-2005 includes by bare name.
*/
`ifndef IOSR_DEFINES_VH
`define IOSR_DEFINES_VH
// ----------------------------------------
// Register indices (word addresses)
// ----------------------------------------
`define IOSR_ADDR_W 6
`define IOSR_VIN_FUNC 6'h00
`define IOSR_VIN_SRC 6'h04
`define IOSR_VIN_INV 6'h08
`define IOSR_VIN_DEAD 6'h0C
`define IOSR_VIN_SHOT 6'h10
`define IOSR_DOUT_FUNC 6'h14
`define IOSR_DOUT_INV 6'h1A
`define IOSR_DOUT_DLY 6'h20
`define IOSR_DOUT_LOGIC 6'h26
`define IOSR_DOUT_CFUNC 6'h2C
`define IOSR_DOUT_CINV 6'h32
`define IOSR_STATUS 6'h38
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define IOSR_CODE_NONE 8'h00
`define IOSR_CODE_CONST_OFF 8'h80
`define IOSR_CODE_HOME_END 8'h90
`define IOSR_CODE_TORQUE_OFF_MON 8'h89
`define IOSR_CODE_SERVO_ON_MON 8'h8E
`define IOSR_CODE_MOVE 8'h86
`define IOSR_CODE_ALARM_LOW 8'h82
`define IOSR_LOGIC_OR 1'b1
`define IOSR_TIME_MAX 8'hFA
// ----------------------------------------
// Timing
// ----------------------------------------
`define IOSR_CLK_MHZ 100
`define IOSR_TICK_US 1000
`define IOSR_TICK_CYC (`IOSR_TICK_US * `IOSR_CLK_MHZ)
`endif

// ### src/iosr_io_routing.v
/*
 I/O signal routing and conditioning: four loopback inputs fed from output-status
 codes, six direct output terminals with inversion, OFF delay and composite logic.
 Assumes a 256-entry status vector and register port in the same clock domain.
*/
// The address-and-strobe port and the register addresses are this design's own decisions.
// How it works
// - Four loopback inputs, function selector resets none
// - Loopback source code selector resets to 128
// - Loopback inversion bit, reset zero
// - Loopback ON dead time 0..250 ms
// - Loopback one-shot mode bit, reset zero
// - Six terminals with fixed reset output codes
// - Terminal inversion bit, reset zero
// - Terminal OFF delay 0..250 ms
// - Composite combine 0 AND, 1 OR, reset OR
// - Composite source code selector resets to 128
// - Composite inversion bit, reset zero
`timescale 1ns/1ps
`default_nettype none
`include "iosr_defines.vh"
module iosr_io_routing #(
    parameter TICK_CYC = `IOSR_TICK_CYC
) (
    input wire clock,
    input wire rstn,
    input wire [255:0] statusVec,
    input wire [`IOSR_ADDR_W-1:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    output reg [3:0] loopbackInput,
    output reg [31:0] loopbackFunc,
    output reg [5:0] doutPin
);

// ----------------------------------------
// Register map (word index, one byte each)
// ----------------------------------------
// 0x00-0x03 loopback function code, exported unchanged
// 0x04-0x07 loopback source status code
// 0x08-0x0B loopback inversion, bit 0 only
// 0x0C-0x0F loopback ON dead time in ms, clamped to 250
// 0x10-0x13 loopback one-shot enable, bit 0 only
// 0x14-0x19 terminal normal status code
// 0x1A-0x1F terminal normal inversion, bit 0 only
// 0x20-0x25 terminal OFF delay in ms, clamped to 250
// 0x26-0x2B terminal combine, 0 AND, 1 OR
// 0x2C-0x31 terminal composite status code
// 0x32-0x37 terminal composite inversion, bit 0 only
// 0x38 terminal levels, read only
// 0x39 loopback levels, read only
// Writes to read-only or unused indices are dropped
// Status codes 0 and 128 always count as OFF, so an
// unassigned source switches something on only when its inversion bit is set

// ----------------------------------------
// Configuration registers
// ----------------------------------------
reg [7:0] vinFunc_r [0:3];
reg [7:0] vinSrc_r [0:3];
reg [3:0] vinInv_r;
reg [7:0] vinDead_r [0:3];
reg [3:0] vinShot_r;
reg [7:0] doFunc_r [0:5];
reg [5:0] doInv_r;
reg [7:0] doDly_r [0:5];
reg [5:0] doLogic_r;
reg [7:0] doCFunc_r [0:5];
reg [5:0] doCInv_r;

// Time settings above 250 are clamped to the longest legal delay
function [7:0] clampMs;
    input [7:0] v;
    begin
        clampMs = (v > `IOSR_TIME_MAX) ? `IOSR_TIME_MAX : v;
    end
endfunction

// Reset value of terminal function selectors
function [7:0] doReset;
    input integer k;
    begin
        case (k)
            0: doReset = `IOSR_CODE_HOME_END;
            1: doReset = `IOSR_CODE_TORQUE_OFF_MON;
            3: doReset = `IOSR_CODE_SERVO_ON_MON;
            4: doReset = `IOSR_CODE_MOVE;
            5: doReset = `IOSR_CODE_ALARM_LOW;
            default: doReset = `IOSR_CODE_NONE;
        endcase
    end
endfunction

// Status lookup; code 128 is constant-off, code 0 none
function pickSig;
    input [255:0] vec;
    input [7:0] code;
    begin
        pickSig = (code == `IOSR_CODE_CONST_OFF || code == `IOSR_CODE_NONE) ? 1'b0 : vec[code];
    end
endfunction

// ----------------------------------------
// Register writes
// ----------------------------------------
// A write lands at the strobe edge; a read in the next cycle
// already returns the new value
integer i;
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        for (i = 0; i < 4; i = i + 1) begin
            vinFunc_r[i] <= `IOSR_CODE_NONE;
            vinSrc_r[i] <= `IOSR_CODE_CONST_OFF;
            vinDead_r[i] <= 8'h00;
        end
        vinInv_r <= 4'h0;
        vinShot_r <= 4'h0;
        for (i = 0; i < 6; i = i + 1) begin
            doFunc_r[i] <= doReset(i);
            doDly_r[i] <= 8'h00;
            doCFunc_r[i] <= `IOSR_CODE_CONST_OFF;
        end
        doInv_r <= 6'h00;
        doLogic_r <= {6{`IOSR_LOGIC_OR}};
        doCInv_r <= 6'h00;
    end else if (regWr) begin
        for (i = 0; i < 4; i = i + 1) begin
            if (regAddr == `IOSR_VIN_FUNC + i) vinFunc_r[i] <= regWdata;
            if (regAddr == `IOSR_VIN_SRC + i) vinSrc_r[i] <= regWdata;
            if (regAddr == `IOSR_VIN_INV + i) vinInv_r[i] <= regWdata[0];
            if (regAddr == `IOSR_VIN_DEAD + i) vinDead_r[i] <= clampMs(regWdata);
            if (regAddr == `IOSR_VIN_SHOT + i) vinShot_r[i] <= regWdata[0];
        end
        for (i = 0; i < 6; i = i + 1) begin
            if (regAddr == `IOSR_DOUT_FUNC + i) doFunc_r[i] <= regWdata;
            if (regAddr == `IOSR_DOUT_INV + i) doInv_r[i] <= regWdata[0];
            if (regAddr == `IOSR_DOUT_DLY + i) doDly_r[i] <= clampMs(regWdata);
            if (regAddr == `IOSR_DOUT_LOGIC + i) doLogic_r[i] <= regWdata[0];
            if (regAddr == `IOSR_DOUT_CFUNC + i) doCFunc_r[i] <= regWdata;
            if (regAddr == `IOSR_DOUT_CINV + i) doCInv_r[i] <= regWdata[0];
        end
    end
end

// ----------------------------------------
// Read mux, data valid the cycle after the strobe
// ----------------------------------------
reg [7:0] rdNxt;
integer j;
always @* begin
    rdNxt = 8'h00;
    for (j = 0; j < 4; j = j + 1) begin
        if (regAddr == `IOSR_VIN_FUNC + j) rdNxt = vinFunc_r[j];
        if (regAddr == `IOSR_VIN_SRC + j) rdNxt = vinSrc_r[j];
        if (regAddr == `IOSR_VIN_INV + j) rdNxt = {7'h00, vinInv_r[j]};
        if (regAddr == `IOSR_VIN_DEAD + j) rdNxt = vinDead_r[j];
        if (regAddr == `IOSR_VIN_SHOT + j) rdNxt = {7'h00, vinShot_r[j]};
    end
    for (j = 0; j < 6; j = j + 1) begin
        if (regAddr == `IOSR_DOUT_FUNC + j) rdNxt = doFunc_r[j];
        if (regAddr == `IOSR_DOUT_INV + j) rdNxt = {7'h00, doInv_r[j]};
        if (regAddr == `IOSR_DOUT_DLY + j) rdNxt = doDly_r[j];
        if (regAddr == `IOSR_DOUT_LOGIC + j) rdNxt = {7'h00, doLogic_r[j]};
        if (regAddr == `IOSR_DOUT_CFUNC + j) rdNxt = doCFunc_r[j];
        if (regAddr == `IOSR_DOUT_CINV + j) rdNxt = {7'h00, doCInv_r[j]};
    end
    if (regAddr == `IOSR_STATUS) rdNxt = {2'h0, doutPin};
    if (regAddr == `IOSR_STATUS + 1) rdNxt = {4'h0, loopbackInput};
end

// Unmapped addresses and idle cycles read as zero
always @(posedge clock or negedge rstn) begin
    if (!rstn) regRdata <= 8'h00;
    else regRdata <= regRd ? rdNxt : 8'h00;
end

// ----------------------------------------
// Millisecond timebase
// ----------------------------------------
// The tick runs free rather than restarting per input, so a
// dead time or delay of D ms lasts between D-1 and D ticks
// plus one; this keeps one counter for all ten channels.
reg [31:0] tickCnt_r;
reg msTick_r;
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        tickCnt_r <= 32'h0;
        msTick_r <= 1'b0;
    end else if (tickCnt_r == TICK_CYC - 1) begin
        tickCnt_r <= 32'h0;
        msTick_r <= 1'b1;
    end else begin
        tickCnt_r <= tickCnt_r + 32'h1;
        msTick_r <= 1'b0;
    end
end

// ----------------------------------------
// Loopback inputs: invert, dead time, one-shot
// ----------------------------------------
reg [7:0] vinCnt_r [0:3];
reg [3:0] vinOn_r;
reg [3:0] vinLevel;
integer k;
integer p;
// Inversion is applied before the dead time, so the filter
// always measures the conditioned ON level.
// Own loop index, so no variable is written by two processes
always @* begin
    for (p = 0; p < 4; p = p + 1) begin
        vinLevel[p] = pickSig(statusVec, vinSrc_r[p]) ^ vinInv_r[p];
    end
end

// Dead-time counter restarts whenever the source drops, so with a nonzero dead time a one-cycle glitch never passes.
// One-shot pulses last one clock; a consumer sampling only on the
// ms tick would miss them.
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        for (k = 0; k < 4; k = k + 1) vinCnt_r[k] <= 8'h00;
        vinOn_r <= 4'h0;
        loopbackInput <= 4'h0;
        loopbackFunc <= 32'h0;
    end else begin
        for (k = 0; k < 4; k = k + 1) begin
            loopbackFunc[k*8 +: 8] <= vinFunc_r[k];
            if (!vinLevel[k]) begin
                vinCnt_r[k] <= 8'h00;
                vinOn_r[k] <= 1'b0;
            end else if (vinCnt_r[k] >= vinDead_r[k]) begin
                vinOn_r[k] <= 1'b1;
            end else if (msTick_r) begin
                vinCnt_r[k] <= vinCnt_r[k] + 8'h01;
            end
            // one-shot gives a single-cycle pulse on the rising edge
            loopbackInput[k] <= vinShot_r[k] ? (vinLevel[k] && (vinCnt_r[k] >= vinDead_r[k]) && !vinOn_r[k])
                                             : (vinLevel[k] && (vinCnt_r[k] >= vinDead_r[k]));
        end
    end
end

// ----------------------------------------
// Direct outputs: invert, composite, OFF delay
// ----------------------------------------
// Composite with the OR reset default and a constant-off
// composite source passes the normal signal unchanged; with
// AND the same setting forces the terminal OFF.
reg [5:0] doComb;
reg [7:0] doCnt_r [0:5];
reg normSig;
reg compSig;
integer m;
integer q;
always @* begin
    normSig = 1'b0;
    compSig = 1'b0;
    for (q = 0; q < 6; q = q + 1) begin
        normSig = pickSig(statusVec, doFunc_r[q]) ^ doInv_r[q];
        compSig = pickSig(statusVec, doCFunc_r[q]) ^ doCInv_r[q];
        doComb[q] = doLogic_r[q] ? (normSig | compSig) : (normSig & compSig);
    end
end

// Delay counts whole ms ticks after the fall; ON input re-arms it at once
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        for (m = 0; m < 6; m = m + 1) doCnt_r[m] <= 8'h00;
        doutPin <= 6'h00;
    end else begin
        for (m = 0; m < 6; m = m + 1) begin
            if (doComb[m]) begin
                doCnt_r[m] <= 8'h00;
                doutPin[m] <= 1'b1;
            end else if (!doutPin[m] || doCnt_r[m] >= doDly_r[m]) begin
                doutPin[m] <= 1'b0;
            end else if (msTick_r) begin
                doCnt_r[m] <= doCnt_r[m] + 8'h01;
                if (doCnt_r[m] + 8'h01 >= doDly_r[m]) doutPin[m] <= 1'b0;
            end
        end
    end
end

endmodule // iosr_io_routing
`default_nettype wire

// ### sim/iosr_status_model.sv
/*
 Far-side model: the driver's status logic that feeds the output-status vector.
 Assumes one clock shared with the routing block and an active-low async reset.
*/
`timescale 1ns/1ps
`default_nettype none
module iosr_status_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic setEn,
    input wire logic [7:0] setCode,
    input wire logic setVal,
    output logic [255:0] statusVec
);
    // Levels change only at an edge, like the real control logic
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            statusVec <= '0;
        end else if (setEn) begin
            statusVec[setCode] <= setVal;
        end
    end
endmodule // iosr_status_model
`default_nettype wire

// ### sim/iosr_checker.sv
/*
 Checker for the routing block: register port and loopback input 0.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module iosr_checker (
    input wire clock,
    input wire rstn,
    input wire [255:0] statusVec,
    input wire [5:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regRdata,
    input wire [3:0] loopbackInput,
    input wire [31:0] loopbackFunc,
    input wire [5:0] doutPin
);
    // ----
    // Shadow of loopback 0 settings, kept from the write port
    // ----
    logic [7:0] srcSel_r;
    logic [7:0] deadT_r;
    logic inv_r;
    logic shot_r;
    // Codes 0 and 128 never count as ON, whatever the vector says
    wire srcOn = statusVec[srcSel_r] && srcSel_r != 8'h00 && srcSel_r != 8'h80;
    wire on = srcOn ^ inv_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            srcSel_r <= 8'h80;
            deadT_r <= 8'h00;
            inv_r <= 1'b0;
            shot_r <= 1'b0;
        end else if (regWr) begin
            case (regAddr)
                6'h04: srcSel_r <= regWdata;
                6'h08: inv_r <= regWdata[0];
                6'h0C: deadT_r <= regWdata;
                6'h10: shot_r <= regWdata[0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    rdata_idle_a: assert property (regRdata != 8'h00 |-> $past(regRd))
        else $error("read data outside read slot");
    status_read_a: assert property (regRd && regAddr == 6'h38 |=> regRdata == {2'b00, $past(doutPin)})
        else $error("status read wrong");
    func_byte0_a: assert property (regWr && regAddr == 6'h00 |=> ##1 loopbackFunc[7:0] == $past(regWdata, 2))
        else $error("function code 0 not exported");
    func_byte3_a: assert property (regWr && regAddr == 6'h03 |=> ##1 loopbackFunc[31:24] == $past(regWdata, 2))
        else $error("function code 3 not exported");
    vin_pass_a: assert property (deadT_r == 8'h00 && on && (!shot_r || !$past(on)) |=> loopbackInput[0])
        else $error("loopback input not ON");
    vin_fall_a: assert property (!on |=> !loopbackInput[0])
        else $error("loopback input ON without source");
    vin_shot_a: assert property (shot_r && loopbackInput[0] |=> !loopbackInput[0])
        else $error("one-shot pulse too long");
    vin_dead_a: assert property (deadT_r == 8'h02 && on && !$past(on) |=> !loopbackInput[0] [*4])
        else $error("dead time not applied");
endmodule // iosr_checker
bind iosr_io_routing iosr_checker chk (.clock(clock), .rstn(rstn), .statusVec(statusVec), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .loopbackInput(loopbackInput),
    .loopbackFunc(loopbackFunc), .doutPin(doutPin));
`default_nettype wire

// ### sim/iosr_io_routing_test.sv
/*
 Self-checking bench for the routing block with a status-logic model.
 Assumes a shortened millisecond tick of 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module iosr_io_routing_test;
    logic clock, rstn, regWr, regRd, setEn, setVal;
    logic [5:0] regAddr;
    logic [7:0] regWdata, setCode, code;
    wire [255:0] statusVec;
    wire [7:0] regRdata;
    wire [3:0] loopbackInput;
    wire [31:0] loopbackFunc;
    wire [5:0] doutPin;
    integer n_fail, num_checks, seed, i, n;
    iosr_status_model partner (.clock(clock), .rstn(rstn), .setEn(setEn), .setCode(setCode), .setVal(setVal),
        .statusVec(statusVec));
    iosr_io_routing #(.TICK_CYC(4)) uut (.clock(clock), .rstn(rstn), .statusVec(statusVec), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .loopbackInput(loopbackInput),
        .loopbackFunc(loopbackFunc), .doutPin(doutPin));
    // ----
    // Expectations and bus tasks
    // ----
    function logic [7:0] defv(input logic [5:0] a);
        if ((a >= 6'h04 && a < 6'h08) || (a >= 6'h2C && a < 6'h32)) return 8'h80;
        if (a >= 6'h26 && a < 6'h2C) return 8'h01;
        case (a)
            6'h14: return 8'h90;
            6'h15: return 8'h89;
            6'h17: return 8'h8E;
            6'h18: return 8'h86;
            6'h19: return 8'h82;
            default: return 8'h00;
        endcase
    endfunction
    function logic comb(input logic a, input logic b, input logic orMode);
        return orMode ? (a | b) : (a & b);
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock); regWr <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge clock); regWr <= 1'b0;
    endtask
    task rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clock); regRd <= 1'b1; regAddr <= a;
        @(posedge clock); regRd <= 1'b0;
        #1 chk(regRdata, e);
    endtask
    // Status change lands at the second edge
    task st(input logic [7:0] c, input logic v);
        @(posedge clock); setEn <= 1'b1; setCode <= c; setVal <= v;
        @(posedge clock); setEn <= 1'b0;
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        rstn = 0; regWr = 0; regRd = 0; regAddr = 0; regWdata = 0;
        setEn = 0; setVal = 0; setCode = 0; n_fail = 0; num_checks = 0; seed = 32'h12fc;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        for (i = 0; i < 64; i++) rd(i[5:0], defv(i[5:0]));
        for (i = 0; i < 4; i++) begin
            n = $random(seed);
            code = n[7:0];
            wr(i[5:0], code);
            rd(i[5:0], code);
            chk(loopbackFunc[i*8 +: 8], code);
        end
        // Over-range times clamp, bit settings keep bit 0, unmapped writes vanish
        wr(6'h0C, 8'hFB); rd(6'h0C, 8'hFA); wr(6'h23, 8'hFF); rd(6'h23, 8'hFA);
        wr(6'h08, 8'hFF); rd(6'h08, 8'h01); wr(6'h3F, 8'h55); rd(6'h3F, 8'h00);
        wr(6'h0C, 8'h00); wr(6'h08, 8'h00); wr(6'h23, 8'h00);
        n = $random(seed);
        code = 8'h01 + (n[7:0] & 8'h7E);
        wr(6'h04, code); st(code, 1'b1); repeat (2) @(posedge clock);
        #1 chk(loopbackInput[0], 1);
        wr(6'h08, 8'h01); @(posedge clock); #1 chk(loopbackInput[0], 0);
        wr(6'h08, 8'h00); st(code, 1'b0); wr(6'h10, 8'h01); st(code, 1'b1);
        n = 0;
        repeat (6) begin @(posedge clock); #1 n += loopbackInput[0]; end
        chk(n, 1);
        st(code, 1'b0); wr(6'h10, 8'h00); wr(6'h0C, 8'h02); st(code, 1'b1);
        n = 0;
        while (loopbackInput[0] !== 1'b1 && n < 20) begin @(posedge clock); #1 n++; end
        chk(n >= 5 && n <= 10, 1);
        st(code, 1'b0); wr(6'h0C, 8'h00);
        st(8'h82, 1'b1); repeat (2) @(posedge clock);
        #1 chk(doutPin[5], 1);
        wr(6'h25, 8'h03); st(8'h82, 1'b0);
        n = 0;
        while (doutPin[5] !== 1'b0 && n < 30) begin @(posedge clock); #1 n++; end
        chk(n >= 9 && n <= 14, 1);
        wr(6'h1F, 8'h01); @(posedge clock); #1 chk(doutPin[5], 1);
        wr(6'h1F, 8'h00); wr(6'h25, 8'h00); wr(6'h16, 8'h91); wr(6'h2E, 8'h92);
        for (i = 0; i < 16; i++) begin
            wr(6'h28, {7'h00, i[2]}); wr(6'h34, {7'h00, i[3]});
            st(8'h91, i[0]); st(8'h92, i[1]); repeat (2) @(posedge clock);
            #1 chk(doutPin[2], comb(i[0], i[1] ^ i[3], i[2]));
        end
        stop_test;
    end
endmodule // iosr_io_routing_test
`default_nettype wire
